// file: rtl/input_filter.sv
// Per-port debounce filter for the synchronised input pins
module input_filter
  import input_function_pkg::*;
#(
  parameter int W = NPORT,
  parameter int CW = FILT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels and setting
  input wire logic [W-1:0] din,
  input wire logic [CW-1:0] filt_len,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0][CW-1:0] cnt;
    logic [W-1:0] level;
  } filt_state_t;

  filt_state_t s_r;
  filt_state_t s_nxt;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // A port takes a new level only after it has differed for filt_len+1
  // cycles; a glitch restarts the count.
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < W; i++) begin
      if (din[i] == s_r.level[i]) begin
        s_nxt.cnt[i] = '0;
      end else if (s_r.cnt[i] >= filt_len) begin
        s_nxt.level[i] = din[i];
        s_nxt.cnt[i] = '0;
      end else begin
        s_nxt.cnt[i] = s_r.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.level;

endmodule

// file: rtl/input_function_decoder.sv
// Decoder of configurable parallel input ports into controller commands
module input_function_decoder
  import input_function_pkg::*;
#(
  parameter int NP = NPORT,
  parameter logic [FILT_W-1:0] FILT_DEFAULT = FILT_LEN_RST
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  // Input pins and the mode selector switch
  input wire logic [NP-1:0] in_pins,
  input wire logic auto_manual_selector,
  // Controller state, same clock domain
  input wire logic op_running,
  input wire logic fault_removed,
  // Commands
  output cmd_out_t cmd
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NP-1:0] pin_s1;
    logic [NP-1:0] pin_s2;
    logic sel_s1;
    logic sel_s2;
    logic [NFUNC-1:0] fn_prev;
    logic bcd_sel;
    logic sync_pair;
    logic [NAXIS-1:0] valid;
    logic [NAXIS-1:0] incr;
    logic [NAXIS-1:0] owned;
    logic [FILT_W-1:0] filt_len;
    logic [NP-1:0][FUNC_W-1:0] func;
    apb_rsp_t rsp;
    cmd_out_t cmd;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  logic [NP-1:0] filt_lvl;

  // ----------------------------------------------------------------
  // Debounce
  // ----------------------------------------------------------------
  input_filter #(
    .W(NP),
    .CW(FILT_W)
  ) u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .din(s_r.pin_s2),
    .filt_len(s_r.filt_len),
    .dout(filt_lvl)
  );

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  // Several ports may carry the same function; they are ORed.
  logic [NFUNC-1:0] fn_lvl;
  logic [NFUNC-1:0] fn_raw;
  logic [NFUNC-1:0] fn_rise;

  always_comb begin
    fn_lvl = '0;
    fn_raw = '0;
    for (int p = 0; p < NP; p++) begin
      fn_lvl[s_r.func[p]] = fn_lvl[s_r.func[p]] | filt_lvl[p];
      fn_raw[s_r.func[p]] = fn_raw[s_r.func[p]] | s_r.pin_s2[p];
    end
    fn_rise = fn_lvl & ~s_r.fn_prev;
  end

  // ----------------------------------------------------------------
  // Program number
  // ----------------------------------------------------------------
  // Bits 1..4 weigh the same in both codes; bits 5..7 differ.
  logic [PROG_W-1:0] num_bin;
  logic [PROG_W-1:0] num_bcd;

  always_comb begin
    num_bin = '0;
    num_bcd = '0;
    for (int b = 0; b < PROG_BITS; b++) begin
      if (fn_lvl[int'(FN_PROG_BIT1) + b]) begin
        num_bin = num_bin | BIN_WEIGHT[b];
        num_bcd = num_bcd + BCD_WEIGHT[b];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  logic setup_ph;
  logic acc_wr;
  logic [ADDR_W-1:0] addr;
  logic func_hit;
  logic [1:0] func_idx;
  logic mapped;
  logic [31:0] rd_word;

  always_comb begin
    addr = apb_req.paddr;
    setup_ph = apb_req.psel && !apb_req.penable;
    acc_wr = apb_req.psel && apb_req.penable && s_r.rsp.pready && apb_req.pwrite
      && !s_r.rsp.pslverr;
    func_hit = (addr >= FUNC_BASE_OFS)
      && (addr < FUNC_BASE_OFS + ADDR_W'(4 * FUNC_WORDS))
      && (addr[1:0] == 2'h0);
    func_idx = 2'(addr[ADDR_W-1:2] - FUNC_BASE_OFS[ADDR_W-1:2]);
    mapped = func_hit;
    rd_word = '0;
    case (addr)
      CTRL_OFS: begin
        mapped = 1'b1;
        rd_word[CTRL_BCD_BIT] = s_r.bcd_sel;
        rd_word[CTRL_SYNC_BIT] = s_r.sync_pair;
      end
      AXIS_CFG_OFS: begin
        mapped = 1'b1;
        rd_word[AXCFG_VALID_LSB +: NAXIS] = s_r.valid;
        rd_word[AXCFG_INCR_LSB +: NAXIS] = s_r.incr;
        rd_word[AXCFG_OWNED_LSB +: NAXIS] = s_r.owned;
      end
      FILTER_OFS: begin
        mapped = 1'b1;
        rd_word[FILT_W-1:0] = s_r.filt_len;
      end
      STATUS_OFS: begin
        mapped = 1'b1;
        rd_word[STAT_PROG_LSB +: PROG_W] = s_r.cmd.prog_num;
        rd_word[STAT_MANUAL_BIT] = s_r.cmd.manual_mode;
        rd_word[STAT_ACCEPT_BIT] = s_r.cmd.move_accept;
        rd_word[STAT_BRAKE_LSB +: NAXIS] = s_r.cmd.brake_release;
      end
      INPUTS_OFS: begin
        mapped = 1'b1;
        rd_word[NP-1:0] = filt_lvl;
      end
      default: begin
        if (func_hit) begin
          for (int j = 0; j < PORTS_PER_WORD; j++) begin
            rd_word[FIELD_STRIDE*j +: FUNC_W] = s_r.func[PORTS_PER_WORD*func_idx + j];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [NAXIS-1:0] brake_own;

  always_comb begin
    s_nxt = s_r;

    // Two-stage synchronisers for the pins and the selector switch
    s_nxt.pin_s1 = in_pins;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.sel_s1 = auto_manual_selector;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.fn_prev = fn_lvl;

    // Slave answers in the first access cycle, data registered
    s_nxt.rsp.pready = setup_ph;
    s_nxt.rsp.pslverr = setup_ph && !mapped;
    s_nxt.rsp.prdata = (setup_ph && !apb_req.pwrite && mapped) ? rd_word : '0;

    if (acc_wr) begin
      case (addr)
        CTRL_OFS: begin
          s_nxt.bcd_sel = apb_req.pwdata[CTRL_BCD_BIT];
          s_nxt.sync_pair = apb_req.pwdata[CTRL_SYNC_BIT];
        end
        AXIS_CFG_OFS: begin
          s_nxt.valid = apb_req.pwdata[AXCFG_VALID_LSB +: NAXIS];
          s_nxt.incr = apb_req.pwdata[AXCFG_INCR_LSB +: NAXIS];
          s_nxt.owned = apb_req.pwdata[AXCFG_OWNED_LSB +: NAXIS];
        end
        FILTER_OFS: begin
          s_nxt.filt_len = apb_req.pwdata[FILT_W-1:0];
        end
        default: begin
          if (func_hit) begin
            for (int j = 0; j < PORTS_PER_WORD; j++) begin
              s_nxt.func[PORTS_PER_WORD*func_idx + j] =
                apb_req.pwdata[FIELD_STRIDE*j +: FUNC_W];
            end
          end
        end
      endcase
    end

    // Program number; any combination of the bits is decoded, the host's pattern is not checked
    s_nxt.cmd.prog_num = s_r.bcd_sel ? num_bcd : num_bin;

    // One-cycle command pulses
    s_nxt.cmd.err_reset = fn_rise[FN_ERR_RESET];
    // Cutoff reset is dropped, not queued, while the fault is still there
    s_nxt.cmd.cutoff_reset = (fn_rise[FN_CUTOFF_RESET] && fault_removed) ?
      s_r.owned : '0;
    // Servo-on sequencing is the host's duty; no check here
    s_nxt.cmd.home_cmd = ({NAXIS{fn_rise[FN_HOME_ALL]}} & s_r.valid)
      | ({NAXIS{fn_rise[FN_HOME_INCR]}} & s_r.valid & s_r.incr);

    // Permission is frozen while an operation runs
    if (!op_running) begin
      s_nxt.cmd.move_accept = fn_lvl[FN_MOVE_ACCEPT];
    end

    s_nxt.cmd.manual_mode = fn_raw[FN_REMOTE_MODE] || s_r.sel_s2;

    brake_own[0] = fn_lvl[FN_BRAKE_AXIS1];
    brake_own[1] = fn_lvl[FN_BRAKE_AXIS2];
    // Axis 2 is the slave of axis 1 when the pair is synchronised
    s_nxt.cmd.brake_release[0] = brake_own[0];
    s_nxt.cmd.brake_release[1] = s_r.sync_pair ? brake_own[0] : brake_own[1];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.filt_len <= FILT_DEFAULT;
      s_r.valid <= VALID_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp = s_r.rsp;
  assign cmd = s_r.cmd;

endmodule

// file: rtl/input_function_pkg.sv
// Constants, register map and carrier types for the input function decoder
package input_function_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPORT = 16;
  localparam int NAXIS = 2;
  localparam int FUNC_W = 5;
  localparam int NFUNC = 32;
  localparam int FILT_W = 8;
  localparam int ADDR_W = 8;
  localparam int PROG_W = 8;
  localparam int PORTS_PER_WORD = 4;
  localparam int FIELD_STRIDE = 8;

  // ----------------------------------------------------------------
  // Input function codes
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FN_PROG_BIT1 = 5'h09;
  localparam logic [FUNC_W-1:0] FN_ERR_RESET = 5'h10;
  localparam logic [FUNC_W-1:0] FN_CUTOFF_RESET = 5'h11;
  localparam logic [FUNC_W-1:0] FN_HOME_ALL = 5'h12;
  localparam logic [FUNC_W-1:0] FN_HOME_INCR = 5'h13;
  localparam logic [FUNC_W-1:0] FN_MOVE_ACCEPT = 5'h14;
  localparam logic [FUNC_W-1:0] FN_REMOTE_MODE = 5'h15;
  localparam logic [FUNC_W-1:0] FN_BRAKE_AXIS1 = 5'h16;
  localparam logic [FUNC_W-1:0] FN_BRAKE_AXIS2 = 5'h17;
  localparam int PROG_BITS = 7;

  // Weights of start-program number bits 1..7
  localparam logic [PROG_BITS-1:0][PROG_W-1:0] BIN_WEIGHT =
    {8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  localparam logic [PROG_BITS-1:0][PROG_W-1:0] BCD_WEIGHT =
    {8'h28, 8'h14, 8'h0a, 8'h08, 8'h04, 8'h02, 8'h01};

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] AXIS_CFG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] FILTER_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] INPUTS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] FUNC_BASE_OFS = 8'h20;
  localparam int FUNC_WORDS = NPORT / PORTS_PER_WORD;

  // Field positions
  localparam int CTRL_BCD_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int AXCFG_VALID_LSB = 0;
  localparam int AXCFG_INCR_LSB = 2;
  localparam int AXCFG_OWNED_LSB = 4;
  localparam int STAT_PROG_LSB = 0;
  localparam int STAT_MANUAL_BIT = 8;
  localparam int STAT_ACCEPT_BIT = 9;
  localparam int STAT_BRAKE_LSB = 10;

  // Reset values
  localparam logic [FILT_W-1:0] FILT_LEN_RST = 8'h10;
  localparam logic [NAXIS-1:0] VALID_RST = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic err_reset;
    logic [NAXIS-1:0] cutoff_reset;
    logic [NAXIS-1:0] home_cmd;
    logic move_accept;
    logic manual_mode;
    logic [NAXIS-1:0] brake_release;
    logic [PROG_W-1:0] prog_num;
  } cmd_out_t;

endpackage

// file: tb/host_pins.sv
// Host controller model driving the decoder's input ports
module host_pins
  import input_function_pkg::*;
(
  // Clock
  input wire logic clk,
  // Wanted and driven levels
  input wire logic [NPORT-1:0] want,
  output logic [NPORT-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Relay outputs change after an edge and then hold their level
  always @(posedge clk) pins <= want;
endmodule

// file: tb/input_function_decoder_checker.sv
// Port assertions for the input function decoder
module input_function_decoder_checker
  import input_function_pkg::*;
#(
  parameter int NP = NPORT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus and inputs
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire logic [NP-1:0] in_pins,
  input wire logic auto_manual_selector,
  input wire logic op_running,
  input wire logic fault_removed,
  // Commands
  input wire cmd_out_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Properties
  // ----
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  // Four samples cover both sync stages and the output register
  sequence manual_held_s;
    auto_manual_selector [*4];
  endsequence
  chk_ready_after_setup: assert property (setup_s |=> apb_rsp.pready)
    else $error("pready late after setup");
  chk_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  chk_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
    else $error("prdata not zero while idle");
  chk_err_pulse:
    assert property (cmd.err_reset |=> !cmd.err_reset) else $error("err_reset too long");
  chk_home_pulse:
    assert property (|cmd.home_cmd |=> cmd.home_cmd == 2'h0) else $error("home_cmd too long");
  chk_cutoff_cause:
    assert property (|cmd.cutoff_reset |-> $past(fault_removed))
    else $error("cutoff reset without fault removed");
  chk_accept_frozen:
    assert property (op_running |=> $stable(cmd.move_accept))
    else $error("move_accept changed while running");
  chk_manual_sel:
    assert property (manual_held_s |=> cmd.manual_mode) else $error("manual_mode missing");
endmodule

bind input_function_decoder input_function_decoder_checker #(.NP(NP)) u_chk (
  .clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp), .in_pins(in_pins),
  .auto_manual_selector(auto_manual_selector), .op_running(op_running),
  .fault_removed(fault_removed), .cmd(cmd));

// file: tb/test_input_function_decoder.sv
// Self-checking testbench of the input function decoder
module test_input_function_decoder
  import input_function_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, man_sw, op_run, fault_ok, e;
  apb_req_t req;
  apb_rsp_t rsp;
  cmd_out_t cmd;
  logic [NPORT-1:0] want, pins;
  logic [31:0] q;
  int err_total, n_tests;

  host_pins u_host (.clk(clk), .want(want), .pins(pins));
  input_function_decoder u_dut (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .in_pins(pins), .auto_manual_selector(man_sw), .op_running(op_run),
    .fault_removed(fault_ok), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    $display("Checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Settled values are read at the falling edge to stay clear of update races
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // The answer is taken at the same rising edge that samples pready high
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk);
      if (rsp.pready) begin
        ok = 1'b1;
        q = rsp.prdata;
        e = rsp.pslverr;
      end
    end
    req <= '0;
    if (!ok) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic pin(input int p, input logic v);
    @(posedge clk);
    want[p] <= v;
    tick(10);
  endtask

  task automatic edge_cmd(input string nm, input int p, input logic [4:0] exp);
    logic [4:0] seen;
    seen = '0;
    @(posedge clk);
    want[p] <= 1'b1;
    repeat (12) begin
      @(negedge clk);
      seen |= {cmd.err_reset, cmd.cutoff_reset, cmd.home_cmd};
    end
    pin(p, 1'b0);
    chk(nm, 32'(exp), 32'(seen));
  endtask

  // ----
  // Scenarios
  // ----
  task automatic s_regs();
    apb(1'b0, AXIS_CFG_OFS, 32'h0);
    chk("axis_cfg", 32'h3, q);
    apb(1'b0, FILTER_OFS, 32'h0);
    chk("filter", 32'h10, q);
    apb(1'b1, 8'h40, 32'hff);
    chk("unmapped", 32'h1, 32'(e));
    // Short filter keeps every pin scenario except s_remote, which sets it to 0xff, within a few cycles
    apb(1'b1, FILTER_OFS, 32'h0);
    apb(1'b1, FUNC_BASE_OFS, 32'h0c0b0a09);
    apb(1'b1, 8'h24, 32'h100f0e0d);
    apb(1'b1, 8'h28, 32'h14131211);
    // Port 12 carries servo-on; home commands do not depend on it
    apb(1'b1, 8'h2c, 32'h17161504);
    apb(1'b0, 8'h2c, 32'h0);
    chk("func3", 32'h17161504, q);
  endtask

  task automatic s_prog();
    logic [7:0] wt [2][4] = '{'{8'h08, 8'h10, 8'h20, 8'h40}, '{8'h08, 8'h0a, 8'h14, 8'h28}};
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, CTRL_OFS, 32'(m));
      for (int b = 0; b < 4; b++) begin
        @(posedge clk);
        want[6:0] <= 7'h08 << b;
        tick(10);
        chk("prog_num", 32'(wt[m][b]), 32'(cmd.prog_num));
      end
    end
    @(posedge clk);
    want[6:0] <= 7'h7f;
    tick(10);
    chk("prog_bcd_all", 32'h55, 32'(cmd.prog_num));
    apb(1'b1, CTRL_OFS, 32'h0);
    tick(10);
    chk("prog_bin_all", 32'h7f, 32'(cmd.prog_num));
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", 32'h7f, q);
    apb(1'b0, INPUTS_OFS, 32'h0);
    chk("inputs", 32'h7f, q);
    @(posedge clk);
    want[6:0] <= 7'h00;
    tick(10);
    chk("prog_none", 32'h0, 32'(cmd.prog_num));
  endtask

  task automatic s_edge();
    apb(1'b1, AXIS_CFG_OFS, 32'h27);
    fault_ok <= 1'b1;
    pin(12, 1'b1);
    edge_cmd("err_reset", 7, 5'h10);
    edge_cmd("cutoff", 8, 5'h08);
    edge_cmd("home_all", 9, 5'h03);
    edge_cmd("home_incr", 10, 5'h01);
    @(posedge clk);
    fault_ok <= 1'b0;
    edge_cmd("cutoff_refused", 8, 5'h00);
  endtask

  task automatic s_accept();
    pin(11, 1'b1);
    chk("accept_on", 32'h1, 32'(cmd.move_accept));
    @(posedge clk);
    op_run <= 1'b1;
    pin(11, 1'b0);
    chk("accept_frozen", 32'h1, 32'(cmd.move_accept));
    @(posedge clk);
    op_run <= 1'b0;
    tick(4);
    chk("accept_off", 32'h0, 32'(cmd.move_accept));
  endtask

  task automatic s_remote();
    // A debounced path would need over 256 cycles here
    apb(1'b1, FILTER_OFS, 32'hff);
    pin(13, 1'b1);
    chk("remote_raw", 32'h1, 32'(cmd.manual_mode));
    pin(13, 1'b0);
    chk("remote_off", 32'h0, 32'(cmd.manual_mode));
    @(posedge clk);
    man_sw <= 1'b1;
    tick(6);
    chk("selector", 32'h1, 32'(cmd.manual_mode));
    @(posedge clk);
    man_sw <= 1'b0;
    apb(1'b1, FILTER_OFS, 32'h0);
  endtask

  task automatic s_brake();
    pin(15, 1'b1);
    chk("brake_ax2", 32'h2, 32'(cmd.brake_release));
    pin(14, 1'b1);
    chk("brake_both", 32'h3, 32'(cmd.brake_release));
    pin(15, 1'b0);
    chk("brake_ax1", 32'h1, 32'(cmd.brake_release));
    apb(1'b1, CTRL_OFS, 32'h2);
    tick(4);
    chk("slave_follows", 32'h3, 32'(cmd.brake_release));
    pin(14, 1'b0);
    pin(15, 1'b1);
    chk("slave_ignores", 32'h0, 32'(cmd.brake_release));
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    rst_b = 1'b0;
    man_sw = 1'b0;
    op_run = 1'b0;
    fault_ok = 1'b0;
    req = '0;
    want = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    s_regs();
    s_prog();
    s_edge();
    s_accept();
    s_remote();
    s_brake();
    end_sim();
  end
endmodule
